// >>> common/gauge_pkg.sv
/*
  Constants, types and helpers of the gauge core.
  Assumes a 20 MHz clock, 8-bit readings.
*/
package gauge_pkg;

  // resolved level of a three-level configuration pin
  typedef enum logic [1:0] {LEVEL_LOW, LEVEL_FLOAT, LEVEL_HIGH} pin_level_type;

  // core clock and end-of-discharge sampling
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned EDV_WINDOW_MS = 4000;
  localparam int unsigned EDV_SAMPLE_COUNT = 8;
  localparam int unsigned SAMPLE_PERIOD_CYCLES =
    EDV_WINDOW_MS * (1000000 / CLK_PERIOD_NS) / EDV_SAMPLE_COUNT;
  localparam logic [3:0] EDV_RUN_LENGTH = 4'h8;

  // settle cycles before the latch
  localparam logic [2:0] SETTLE_LAST = 3'h5;

  // voltage thresholds, reading lsb is 10 mV
  localparam int unsigned VOLT_LSB_MV = 10;
  localparam int unsigned EDV_FIRST_DEFAULT_MV = 760;
  localparam int unsigned EDV_GAP_MV = 100;
  localparam logic [7:0] EDV_FIRST_DEFAULT = 8'(EDV_FIRST_DEFAULT_MV / VOLT_LSB_MV);
  localparam logic [7:0] EDV_GAP = 8'(EDV_GAP_MV / VOLT_LSB_MV);

  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_TEMP = 8'h02;
  localparam logic [7:0] ADDR_VOLT = 8'h0B;
  localparam logic [7:0] ADDR_CAP_LO = 8'h0E;
  localparam logic [7:0] ADDR_CAP_HI = 8'h0F;
  localparam logic [7:0] ADDR_FULL_COUNT = 8'h10;
  localparam logic [7:0] ADDR_FULL_REF = 8'h11;
  localparam logic [7:0] ADDR_PEAK_RATE = 8'h12;
  localparam logic [7:0] ADDR_EDV_THRESH = 8'h13;
  localparam logic [7:0] ADDR_DCOUNT_LO = 8'h2E;
  localparam logic [7:0] ADDR_DCOUNT_HI = 8'h2F;

  // status register bit positions
  localparam int unsigned STATUS_FINAL_BIT = 0;
  localparam int unsigned STATUS_FIRST_BIT = 1;
  localparam int unsigned STATUS_INIT_BIT = 7;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam pin_level_type LEVEL_RESET = LEVEL_FLOAT;

  // efficiency factor is in percent
  localparam logic [23:0] PERCENT_DIV = 24'h000064;

  // table axes: rows deg C, columns C/240
  localparam logic signed [7:0] TEMP_ROW_EDGE [6] =
    '{8'shEC, 8'shF6, 8'sh00, 8'sh15, 8'sh37, 8'sh46};
  localparam logic [7:0] RATE_COL_EDGE [6] =
    '{8'h00, 8'h03, 8'h0A, 8'h18, 8'h30, 8'h50};

  // raw pin code {reads high, reads low}
  function automatic pin_level_type resolve_level(input logic [1:0] raw);
    unique case (raw)
      2'b10: resolve_level = LEVEL_HIGH;
      2'b01: resolve_level = LEVEL_LOW;
      default: resolve_level = LEVEL_FLOAT;
    endcase
  endfunction : resolve_level

  // full count / 256 from pins one and two
  function automatic logic [7:0] full_count_byte(input pin_level_type one,
                                                 input pin_level_type two);
    unique case ({one, two})
      {LEVEL_HIGH, LEVEL_HIGH}: full_count_byte = 8'hBC;
      {LEVEL_HIGH, LEVEL_FLOAT}: full_count_byte = 8'hB4;
      {LEVEL_HIGH, LEVEL_LOW}: full_count_byte = 8'hA9;
      {LEVEL_FLOAT, LEVEL_HIGH}: full_count_byte = 8'h9C;
      {LEVEL_FLOAT, LEVEL_FLOAT}: full_count_byte = 8'h96;
      {LEVEL_FLOAT, LEVEL_LOW}: full_count_byte = 8'h8D;
      {LEVEL_LOW, LEVEL_HIGH}: full_count_byte = 8'h7C;
      {LEVEL_LOW, LEVEL_FLOAT}: full_count_byte = 8'h71;
      default: full_count_byte = 8'h66;
    endcase
  endfunction : full_count_byte

endpackage : gauge_pkg

// >>> common/gauge_eff_if.sv
/*
  Carrier from the gauge core to its lookup.
  Assumes one clock; the lookup is combinational.
*/
`timescale 1ns/100ps
interface gauge_eff_if;
  gauge_pkg::pin_level_type table_level;
  logic [7:0] temperature;
  logic [7:0] rate;
  logic [7:0] factor;
  modport core (output table_level, output temperature, output rate, input factor);
  modport lookup (input table_level, input temperature, input rate, output factor);
endinterface : gauge_eff_if

// >>> verilog/efficiency_lookup.sv
/*
  Efficiency factor lookup: three tables indexed by temperature and rate.
  Assumes a signed temperature in deg C and a rate in C/240 steps.
*/
`timescale 1ns/100ps
module efficiency_lookup (
  // lookup request and factor
  gauge_eff_if.lookup eff
);

  // rows are -20,-10,0,21,55,70 deg C; columns 0,C/80,C/24,C/10,C/5,C/3
  localparam logic [7:0] TABLE_FLOAT [36] = '{
    8'h61, 8'h63, 8'h60, 8'h5C, 8'h55, 8'h51,
    8'h62, 8'h62, 8'h61, 8'h5E, 8'h59, 8'h55,
    8'h62, 8'h62, 8'h61, 8'h5E, 8'h5A, 8'h57,
    8'h63, 8'h63, 8'h62, 8'h60, 8'h5C, 8'h59,
    8'h63, 8'h63, 8'h62, 8'h60, 8'h5D, 8'h5A,
    8'h63, 8'h63, 8'h62, 8'h60, 8'h5D, 8'h5A};
  localparam logic [7:0] TABLE_LOW [36] = '{
    8'h57, 8'h55, 8'h50, 8'h46, 8'h35, 8'h32,
    8'h5D, 8'h5B, 8'h58, 8'h50, 8'h44, 8'h33,
    8'h60, 8'h5E, 8'h5B, 8'h55, 8'h4A, 8'h3C,
    8'h63, 8'h61, 8'h5F, 8'h59, 8'h51, 8'h44,
    8'h64, 8'h63, 8'h61, 8'h5C, 8'h55, 8'h4A,
    8'h65, 8'h64, 8'h62, 8'h5D, 8'h56, 8'h4C};
  localparam logic [7:0] TABLE_HIGH [36] = '{
    8'h5C, 8'h5D, 8'h5C, 8'h58, 8'h53, 8'h4B,
    8'h62, 8'h62, 8'h61, 8'h5D, 8'h59, 8'h51,
    8'h64, 8'h64, 8'h63, 8'h60, 8'h5B, 8'h54,
    8'h68, 8'h68, 8'h66, 8'h63, 8'h5F, 8'h58,
    8'h6A, 8'h6A, 8'h69, 8'h64, 8'h61, 8'h5A,
    8'h6B, 8'h6B, 8'h69, 8'h65, 8'h62, 8'h5B};

  // index of nearest lower row and column
  function automatic logic [5:0] table_index(input logic [7:0] temp, input logic [7:0] rate);
    logic [2:0] row;
    logic [2:0] col;
    row = 3'h0;
    col = 3'h0;
    for (int i = 1; i < 6; i++) begin
      if ($signed(temp) >= gauge_pkg::TEMP_ROW_EDGE[i]) row = 3'(i);
      if (rate >= gauge_pkg::RATE_COL_EDGE[i]) col = 3'(i);
    end
    table_index = 6'(row) * 6'h06 + 6'(col);
  endfunction : table_index

  logic [5:0] index;

  // table chosen by pin four
  always_comb begin
    index = table_index(eff.temperature, eff.rate);
    unique case (eff.table_level)
      gauge_pkg::LEVEL_LOW: eff.factor = TABLE_LOW[index];
      gauge_pkg::LEVEL_HIGH: eff.factor = TABLE_HIGH[index];
      default: eff.factor = TABLE_FLOAT[index];
    endcase
  end

endmodule : efficiency_lookup

// >>> verilog/gauge_core.sv
/*
  Gauge core: empty thresholds, discharge count,
  compensated capacity and configuration latch.
  Assumes the register port and the front-end
  strobes all run on CORE_CLK.
*/
`timescale 1ns/100ps
module gauge_core #(
  parameter int unsigned SAMPLE_CYCLES = gauge_pkg::SAMPLE_PERIOD_CYCLES
) (
  // clock, reset and enable
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // initialization request
  input wire logic INIT_REQ,
  // configuration pins, raw code {reads high, reads low}
  input wire logic [1:0] CONFIG_PIN_ONE,
  input wire logic [1:0] CONFIG_PIN_TWO,
  input wire logic [1:0] CONFIG_PIN_SCALE,
  input wire logic [1:0] CONFIG_PIN_COMPENSATION,
  input wire logic [1:0] CONFIG_PIN_DISPLAY,
  input wire logic [1:0] CONFIG_PIN_INITIAL_FILL,
  // measurements
  output logic SAMPLE_REQ,
  input wire logic BATTERY_SENSE_VALID,
  input wire logic [7:0] BATTERY_SENSE_INPUT,
  input wire logic TEMP_VALID,
  input wire logic [7:0] TEMP_VALUE,
  input wire logic DISCHARGE_TICK,
  input wire logic RATE_VALID,
  input wire logic [7:0] RATE_VALUE,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD_EN,
  input wire logic REG_WR_EN,
  input wire logic [7:0] REG_WR_DATA,
  output logic [7:0] REG_RD_DATA,
  // latched settings and flags
  output logic [1:0] SCALE_CODE,
  output logic [1:0] DISPLAY_CODE,
  output logic [1:0] EMPTY_FLAGS
);

  typedef enum logic {PHASE_SETTLE, PHASE_RUN} phase_type;

  phase_type phase_reg;
  logic [2:0] settle_reg;
  logic latch_now;
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  logic [11:0] sync3_reg;
  logic [11:0] stable_reg;
  gauge_pkg::pin_level_type one_now;
  gauge_pkg::pin_level_type two_now;
  gauge_pkg::pin_level_type scale_reg;
  gauge_pkg::pin_level_type comp_reg;
  gauge_pkg::pin_level_type display_reg;
  logic [7:0] full_count_reg;
  logic [7:0] full_ref_reg;
  logic [7:0] edv_first_reg;
  logic [7:0] edv_final;
  logic [7:0] volt_reg;
  logic [3:0] first_run_reg;
  logic [3:0] final_run_reg;
  logic [3:0] first_run_next;
  logic [3:0] final_run_next;
  logic first_flag_reg;
  logic final_flag_reg;
  logic [7:0] temp_reg;
  logic [15:0] dcount_reg;
  logic [7:0] peak_rate_reg;
  logic [15:0] cap_reg;
  logic [15:0] cap_next;
  logic [15:0] eff_product;
  logic [23:0] comp_full;
  logic [23:0] cap_diff;
  logic [23:0] sample_cnt_reg;
  logic sample_req_reg;
  logic [7:0] rd_next;
  logic [7:0] status_byte;

  gauge_eff_if eff ();

  efficiency_lookup u_lookup (
    .eff(eff.lookup)
  );

  // consecutive low-sample run, saturating at the run length
  function automatic logic [3:0] next_run(input logic [3:0] run, input logic below);
    if (!below) next_run = 4'h0;
    else if (run == gauge_pkg::EDV_RUN_LENGTH) next_run = run;
    else next_run = run + 4'h1;
  endfunction : next_run

  function automatic logic write_hit(input logic en, input logic [7:0] addr,
                                     input logic [7:0] target);
    write_hit = en && (addr == target);
  endfunction : write_hit

  // 3-stage pin sync; a bit moves once stages 2 and 3 agree
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
      sync3_reg <= 12'h000;
      stable_reg <= 12'h000;
    end else if (CLK_EN) begin
      sync1_reg <= {CONFIG_PIN_ONE, CONFIG_PIN_TWO, CONFIG_PIN_SCALE,
                    CONFIG_PIN_COMPENSATION, CONFIG_PIN_DISPLAY, CONFIG_PIN_INITIAL_FILL};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (stable_reg & (sync2_reg ^ sync3_reg));
    end
  end

  assign one_now = gauge_pkg::resolve_level(stable_reg[11:10]);
  assign two_now = gauge_pkg::resolve_level(stable_reg[9:8]);

  // init: settle after reset or request, then latch
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_reg <= PHASE_SETTLE;
      settle_reg <= 3'h0;
    end else if (CLK_EN) begin
      unique case (phase_reg)
        PHASE_SETTLE: begin
          settle_reg <= settle_reg + 3'h1;
          if (latch_now) phase_reg <= PHASE_RUN;
        end
        PHASE_RUN: begin
          settle_reg <= 3'h0;
          if (INIT_REQ) phase_reg <= PHASE_SETTLE;
        end
      endcase
    end
  end

  assign latch_now = (phase_reg == PHASE_SETTLE) && (settle_reg == gauge_pkg::SETTLE_LAST);

  // latch of three pin levels and full count
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scale_reg <= gauge_pkg::LEVEL_RESET;
      comp_reg <= gauge_pkg::LEVEL_RESET;
      display_reg <= gauge_pkg::LEVEL_RESET;
      full_count_reg <= gauge_pkg::BYTE_RESET;
    end else if (CLK_EN && latch_now) begin
      full_count_reg <= gauge_pkg::full_count_byte(one_now, two_now);
      scale_reg <= gauge_pkg::resolve_level(stable_reg[7:6]);
      comp_reg <= gauge_pkg::resolve_level(stable_reg[5:4]);
      display_reg <= gauge_pkg::resolve_level(stable_reg[3:2]);
    end
  end

  // full reference: init load or host write
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      full_ref_reg <= gauge_pkg::BYTE_RESET;
    end else if (CLK_EN) begin
      if (latch_now) begin
        if (gauge_pkg::resolve_level(stable_reg[1:0]) == gauge_pkg::LEVEL_HIGH)
          full_ref_reg <= gauge_pkg::full_count_byte(one_now, two_now);
        else
          full_ref_reg <= gauge_pkg::BYTE_RESET;
      end else if (write_hit(REG_WR_EN, REG_ADDR, gauge_pkg::ADDR_FULL_REF)) begin
        full_ref_reg <= REG_WR_DATA;
      end
    end
  end

  // first threshold; final is a fixed gap below
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      edv_first_reg <= gauge_pkg::EDV_FIRST_DEFAULT;
    end else if (CLK_EN && write_hit(REG_WR_EN, REG_ADDR, gauge_pkg::ADDR_EDV_THRESH)) begin
      edv_first_reg <= REG_WR_DATA;
    end
  end

  assign edv_final = (edv_first_reg > gauge_pkg::EDV_GAP) ? edv_first_reg - gauge_pkg::EDV_GAP :
                     gauge_pkg::BYTE_RESET;

  // eight sample requests per window
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sample_cnt_reg <= 24'h000000;
      sample_req_reg <= 1'b0;
    end else if (CLK_EN) begin
      sample_req_reg <= 1'b0;
      if (sample_cnt_reg == 24'(SAMPLE_CYCLES - 1)) begin
        sample_cnt_reg <= 24'h000000;
        sample_req_reg <= 1'b1;
      end else begin
        sample_cnt_reg <= sample_cnt_reg + 24'h000001;
      end
    end
  end

  assign first_run_next = next_run(first_run_reg, BATTERY_SENSE_INPUT < edv_first_reg);
  assign final_run_next = next_run(final_run_reg, BATTERY_SENSE_INPUT < edv_final);

  // voltage reading and low-sample runs
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      volt_reg <= gauge_pkg::BYTE_RESET;
      first_run_reg <= 4'h0;
      final_run_reg <= 4'h0;
    end else if (CLK_EN) begin
      if (latch_now) begin
        first_run_reg <= 4'h0;
        final_run_reg <= 4'h0;
      end else if (BATTERY_SENSE_VALID) begin
        first_run_reg <= first_run_next;
        final_run_reg <= final_run_next;
      end
      if (BATTERY_SENSE_VALID) volt_reg <= BATTERY_SENSE_INPUT;
    end
  end

  // sticky empty flags, cleared only by initialization
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      first_flag_reg <= 1'b0;
      final_flag_reg <= 1'b0;
    end else if (CLK_EN) begin
      if (latch_now) begin
        first_flag_reg <= 1'b0;
        final_flag_reg <= 1'b0;
      end else if (BATTERY_SENSE_VALID) begin
        first_flag_reg <= first_flag_reg | (first_run_next == gauge_pkg::EDV_RUN_LENGTH);
        final_flag_reg <= final_flag_reg | (final_run_next == gauge_pkg::EDV_RUN_LENGTH);
      end
    end
  end

  // temperature capture
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      temp_reg <= gauge_pkg::BYTE_RESET;
    end else if (CLK_EN && TEMP_VALID) begin
      temp_reg <= TEMP_VALUE;
    end
  end

  // discharge counter, saturating, restarted by initialization
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dcount_reg <= gauge_pkg::WORD_RESET;
    end else if (CLK_EN) begin
      if (latch_now) dcount_reg <= gauge_pkg::WORD_RESET;
      else if (DISCHARGE_TICK && dcount_reg != 16'hFFFF) dcount_reg <= dcount_reg + 16'h0001;
    end
  end

  // peak discharge rate for the cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      peak_rate_reg <= gauge_pkg::BYTE_RESET;
    end else if (CLK_EN) begin
      if (latch_now) peak_rate_reg <= gauge_pkg::BYTE_RESET;
      else if (RATE_VALID && RATE_VALUE > peak_rate_reg) peak_rate_reg <= RATE_VALUE;
    end
  end

  // lookup: latched table, peak rate, live temperature
  assign eff.table_level = comp_reg;
  assign eff.rate = peak_rate_reg;
  assign eff.temperature = temp_reg;

  // full reference is in units of 256 counts, factor in percent
  assign eff_product = {8'h00, full_ref_reg} * {8'h00, eff.factor};
  assign comp_full = {eff_product, 8'h00} / gauge_pkg::PERCENT_DIV;
  assign cap_diff = comp_full - {8'h00, dcount_reg};

  // clamp below at zero and above at the register range
  always_comb begin
    if (comp_full <= {8'h00, dcount_reg}) cap_next = gauge_pkg::WORD_RESET;
    else if (cap_diff[23:16] != 8'h00) cap_next = 16'hFFFF;
    else cap_next = cap_diff[15:0];
  end

  // capacity recomputed every enabled cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cap_reg <= gauge_pkg::WORD_RESET;
    end else if (CLK_EN) begin
      cap_reg <= cap_next;
    end
  end

  // status byte: init in progress and both empty flags
  always_comb begin
    status_byte = 8'h00;
    status_byte[gauge_pkg::STATUS_INIT_BIT] = (phase_reg == PHASE_SETTLE);
    status_byte[gauge_pkg::STATUS_FIRST_BIT] = first_flag_reg;
    status_byte[gauge_pkg::STATUS_FINAL_BIT] = final_flag_reg;
  end

  // register read decode; unmapped offsets read zero
  always_comb begin
    unique case (REG_ADDR)
      gauge_pkg::ADDR_STATUS: rd_next = status_byte;
      gauge_pkg::ADDR_TEMP: rd_next = temp_reg;
      gauge_pkg::ADDR_VOLT: rd_next = volt_reg;
      gauge_pkg::ADDR_CAP_LO: rd_next = cap_reg[7:0];
      gauge_pkg::ADDR_CAP_HI: rd_next = cap_reg[15:8];
      gauge_pkg::ADDR_FULL_COUNT: rd_next = full_count_reg;
      gauge_pkg::ADDR_FULL_REF: rd_next = full_ref_reg;
      gauge_pkg::ADDR_PEAK_RATE: rd_next = peak_rate_reg;
      gauge_pkg::ADDR_EDV_THRESH: rd_next = edv_first_reg;
      gauge_pkg::ADDR_DCOUNT_LO: rd_next = dcount_reg[7:0];
      gauge_pkg::ADDR_DCOUNT_HI: rd_next = dcount_reg[15:8];
      default: rd_next = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RD_DATA <= gauge_pkg::BYTE_RESET;
    end else if (CLK_EN && REG_RD_EN) begin
      REG_RD_DATA <= rd_next;
    end
  end

  assign SAMPLE_REQ = sample_req_reg;
  assign SCALE_CODE = scale_reg;
  assign DISPLAY_CODE = display_reg;
  assign EMPTY_FLAGS = {first_flag_reg, final_flag_reg};

endmodule : gauge_core

// >>> test/gauge_core_checker.sv
/*
  Checker of the gauge core ports.
  Assumes a bind into gauge_core, CLK_EN high.
*/
`timescale 1ns/100ps
module gauge_core_checker #(
  parameter int unsigned SAMPLE_CYCLES = 20
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // watched inputs
  input wire logic INIT_REQ,
  input wire logic BATTERY_SENSE_VALID,
  input wire logic [7:0] BATTERY_SENSE_INPUT,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD_EN,
  input wire logic REG_WR_EN,
  input wire logic [7:0] REG_WR_DATA,
  // watched outputs
  input wire logic SAMPLE_REQ,
  input wire logic [7:0] REG_RD_DATA,
  input wire logic [1:0] SCALE_CODE,
  input wire logic [1:0] EMPTY_FLAGS
);
  localparam int PER = SAMPLE_CYCLES;
  logic [3:0] since_init_reg;
  logic [3:0] low_run_reg;
  logic [7:0] thresh_reg;
  logic [7:0] volt_reg;
  logic [23:0] gap_reg;
  logic quiet;
  assign quiet = (since_init_reg == 4'hF) && !INIT_REQ;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // cycles since the last initialization request, saturating
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) since_init_reg <= 4'h0;
    else if (INIT_REQ) since_init_reg <= 4'h0;
    else if (since_init_reg != 4'hF) since_init_reg <= since_init_reg + 4'h1;
  end
  // first threshold as the host last wrote it
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) thresh_reg <= gauge_pkg::EDV_FIRST_DEFAULT;
    else if (REG_WR_EN && REG_ADDR == gauge_pkg::ADDR_EDV_THRESH) thresh_reg <= REG_WR_DATA;
  end
  // latest battery sample
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) volt_reg <= 8'h00;
    else if (BATTERY_SENSE_VALID) volt_reg <= BATTERY_SENSE_INPUT;
  end
  // run of consecutive samples below the first threshold
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) low_run_reg <= 4'h0;
    else if (INIT_REQ || (BATTERY_SENSE_VALID && BATTERY_SENSE_INPUT >= thresh_reg))
      low_run_reg <= 4'h0;
    else if (BATTERY_SENSE_VALID && low_run_reg != 4'h8) low_run_reg <= low_run_reg + 4'h1;
  end
  // cycles since the last sample request
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) gap_reg <= 24'h000000;
    else gap_reg <= SAMPLE_REQ ? 24'h000001 : gap_reg + 24'h000001;
  end
  AST_FLAG_RUN: assert property ($rose(EMPTY_FLAGS[1]) |-> low_run_reg == 4'h8)
    else $error("early first flag");
  AST_FINAL_FIRST: assert property (EMPTY_FLAGS[0] |-> EMPTY_FLAGS[1])
    else $error("final without first");
  AST_FLAG_STICKY: assert property (EMPTY_FLAGS[1] && quiet |=> EMPTY_FLAGS[1])
    else $error("first flag dropped");
  AST_FINAL_CLEAR: assert property ($fell(EMPTY_FLAGS[0]) |-> since_init_reg < 4'hA)
    else $error("final flag dropped");
  AST_SAMPLE_GAP: assert property (SAMPLE_REQ |=> !SAMPLE_REQ [*8])
    else $error("requests too close");
  AST_SAMPLE_PERIOD: assert property (SAMPLE_REQ |-> gap_reg == 24'(PER))
    else $error("bad sample period");
  AST_RD_HOLD: assert property (!REG_RD_EN |=> $stable(REG_RD_DATA))
    else $error("read data moved");
  AST_RD_UNMAPPED: assert property (REG_RD_EN && REG_ADDR == 8'h05 |=> REG_RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  AST_STATUS_READ: assert property (REG_RD_EN && REG_ADDR == gauge_pkg::ADDR_STATUS |=>
    REG_RD_DATA[1:0] == $past(EMPTY_FLAGS) && REG_RD_DATA[6:2] == 5'h00)
    else $error("bad status read");
  AST_VOLT_READ: assert property (REG_RD_EN && REG_ADDR == gauge_pkg::ADDR_VOLT &&
    !BATTERY_SENSE_VALID |=> REG_RD_DATA == volt_reg)
    else $error("bad voltage read");
  AST_SCALE_HELD: assert property (quiet |=> $stable(SCALE_CODE))
    else $error("scale moved");
endmodule : gauge_core_checker

bind gauge_core gauge_core_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_gauge_core_checker (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .INIT_REQ(INIT_REQ),
  .BATTERY_SENSE_VALID(BATTERY_SENSE_VALID), .BATTERY_SENSE_INPUT(BATTERY_SENSE_INPUT),
  .REG_ADDR(REG_ADDR), .REG_RD_EN(REG_RD_EN), .REG_WR_EN(REG_WR_EN),
  .REG_WR_DATA(REG_WR_DATA), .SAMPLE_REQ(SAMPLE_REQ), .REG_RD_DATA(REG_RD_DATA),
  .SCALE_CODE(SCALE_CODE), .EMPTY_FLAGS(EMPTY_FLAGS)
);

// >>> test/gauge_host_model.sv
/*
  Register host: one access a call.
  Assumes requests taken on rising core_clk.
*/
`timescale 1ns/100ps
module gauge_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_rd_en = 1'b0,
  output logic reg_wr_en = 1'b0,
  output logic [7:0] reg_wr_data = 8'h00,
  input wire logic [7:0] reg_rd_data
);
  // one access over one edge; idle lines scrambled
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge core_clk);
    reg_addr = addr;
    reg_wr_data = wdata;
    reg_rd_en = !wr;
    reg_wr_en = wr;
    @(negedge core_clk);
    rdata = reg_rd_data;
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b0;
    reg_addr = ~addr;
    reg_wr_data = ~wdata;
  endtask : access
endmodule : gauge_host_model

// >>> test/test_gauge_core.sv
/*
  Bench of the gauge core with a register host.
  Assumes a short sample period.
*/
`timescale 1ns/100ps
module test_gauge_core;
  localparam int unsigned SAMPLE_CYCLES = 20;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic init_req = 1'b0;
  logic [1:0] pins [6] = '{2'b01, 2'b01, 2'b10, 2'b00, 2'b11, 2'b10};
  logic volt_valid = 1'b0, temp_valid = 1'b0, tick = 1'b0, rate_valid = 1'b0;
  logic [7:0] volt = 8'h00, temp = 8'h00, rate = 8'h00, v, rdata;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic reg_rd_en, reg_wr_en;
  logic [1:0] scale_code, empty_flags;
  logic [15:0] word;
  logic [1:0] raw_tab [3] = '{2'b01, 2'b00, 2'b10};
  logic [7:0] fc_tab [9] = '{8'h66, 8'h71, 8'h7C, 8'h8D, 8'h96, 8'h9C, 8'hA9, 8'hB4, 8'hBC};
  int f55 [3] = '{100, 99, 106};
  int errors = 0, samples_checked = 0, seed, n, i;
  // core clock
  always #25 core_clk = ~core_clk;
  // device under test and its host
  gauge_core #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_gauge_core (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .CLK_EN(1'b1), .INIT_REQ(init_req),
    .CONFIG_PIN_ONE(pins[0]), .CONFIG_PIN_TWO(pins[1]), .CONFIG_PIN_SCALE(pins[2]),
    .CONFIG_PIN_COMPENSATION(pins[3]), .CONFIG_PIN_DISPLAY(pins[4]),
    .CONFIG_PIN_INITIAL_FILL(pins[5]), .SAMPLE_REQ(), .BATTERY_SENSE_VALID(volt_valid),
    .BATTERY_SENSE_INPUT(volt), .TEMP_VALID(temp_valid), .TEMP_VALUE(temp),
    .DISCHARGE_TICK(tick), .RATE_VALID(rate_valid), .RATE_VALUE(rate),
    .REG_ADDR(reg_addr), .REG_RD_EN(reg_rd_en), .REG_WR_EN(reg_wr_en),
    .REG_WR_DATA(reg_wr_data), .REG_RD_DATA(reg_rd_data), .SCALE_CODE(scale_code),
    .DISPLAY_CODE(), .EMPTY_FLAGS(empty_flags));
  gauge_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
  // expected capacity, clamped at zero
  function automatic logic [15:0] exp_cap(input int fr, input int f, input int d);
    int t;
    t = fr * f * 256 / 100 - d;
    return (t < 0) ? 16'h0000 : 16'(t);
  endfunction : exp_cap
  // compare one result and count it
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one measurement strobe: 0 voltage, 1 temperature, 2 tick, 3 rate
  task automatic strobe(input int kind, input logic [7:0] x);
    @(negedge core_clk);
    {volt, temp, rate} = {x, x, x};
    {volt_valid, temp_valid, tick, rate_valid} = 4'b1000 >> kind;
    @(negedge core_clk);
    {volt_valid, temp_valid, tick, rate_valid} = 4'b0000;
    {volt, temp, rate} = ~{volt, temp, rate};
  endtask : strobe
  // settled two-byte read
  task automatic rd16(input logic [7:0] a);
    repeat (2) @(negedge core_clk);
    i_host.access(1'b0, a, 8'h00, word[7:0]);
    i_host.access(1'b0, a + 8'h01, 8'h00, word[15:8]);
  endtask : rd16
  // init pulse on steady pins
  task automatic reinit;
    repeat (6) @(negedge core_clk);
    init_req = 1'b1;
    @(negedge core_clk);
    init_req = 1'b0;
    repeat (12) @(negedge core_clk);
  endtask : reinit
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    seed = 32'h994791D1;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (12) @(negedge core_clk);
    check("scale", 16'h0002, {14'h0, scale_code});
    i_host.access(1'b0, gauge_pkg::ADDR_FULL_REF, 8'h00, rdata);
    check("full ref", 16'h0066, {8'h00, rdata});
    i_host.access(1'b0, 8'h05, 8'h00, rdata);
    for (i = 0; i < 9; i++) begin
      pins = '{raw_tab[i / 3], raw_tab[i % 3], raw_tab[i % 3], raw_tab[1], 2'b11,
               raw_tab[2 * (i % 2)]};
      reinit();
      check("scale", 16'(i % 3), {14'h0, scale_code});
      i_host.access(1'b0, gauge_pkg::ADDR_FULL_COUNT, 8'h00, rdata);
      check("full count", {8'h00, fc_tab[i]}, {8'h00, rdata});
      i_host.access(1'b0, gauge_pkg::ADDR_FULL_REF, 8'h00, rdata);
      check("full ref", (i % 2) ? {8'h00, fc_tab[i]} : 16'h0000, {8'h00, rdata});
    end
    i_host.access(1'b1, gauge_pkg::ADDR_FULL_REF, 8'h66, rdata);
    repeat (6) begin
      v = 8'h50 + 8'($unsigned($random(seed)) % 32'd170);
      strobe(0, v);
      i_host.access(1'b0, gauge_pkg::ADDR_VOLT, 8'h00, rdata);
      check("voltage", {8'h00, v}, {8'h00, rdata});
    end
    repeat (7) strobe(0, 8'd70);
    strobe(0, 8'd90);
    repeat (7) strobe(0, 8'd70);
    check("flags", 16'h0000, {14'h0, empty_flags});
    strobe(0, 8'd70);
    check("flags", 16'h0002, {14'h0, empty_flags});
    repeat (8) strobe(0, 8'd50);
    repeat (2) strobe(0, 8'd200);
    check("flags", 16'h0003, {14'h0, empty_flags});
    i_host.access(1'b0, gauge_pkg::ADDR_STATUS, 8'h00, rdata);
    check("status", 16'h0003, {8'h00, rdata});
    strobe(1, 8'd25);
    i_host.access(1'b0, gauge_pkg::ADDR_TEMP, 8'h00, rdata);
    check("temperature", 16'd25, {8'h00, rdata});
    n = 240 + int'($unsigned($random(seed)) % 32'd40);
    repeat (n) strobe(2, 8'h00);
    rd16(gauge_pkg::ADDR_DCOUNT_LO);
    check("discharge count", 16'(n), word);
    rd16(gauge_pkg::ADDR_CAP_LO);
    check("capacity", exp_cap(102, 99, n), word);
    strobe(3, 8'd80);
    strobe(3, 8'd10);
    i_host.access(1'b0, gauge_pkg::ADDR_PEAK_RATE, 8'h00, rdata);
    check("peak rate", 16'd80, {8'h00, rdata});
    rd16(gauge_pkg::ADDR_CAP_LO);
    check("capacity", exp_cap(102, 89, n), word);
    strobe(1, 8'd60);
    rd16(gauge_pkg::ADDR_CAP_LO);
    check("capacity", exp_cap(102, 90, n), word);
    i_host.access(1'b1, gauge_pkg::ADDR_FULL_REF, 8'h01, rdata);
    rd16(gauge_pkg::ADDR_CAP_LO);
    check("capacity", exp_cap(1, 90, n), word);
    for (i = 0; i < 3; i++) begin
      pins[3] = raw_tab[i];
      reinit();
      check("flags", 16'h0000, {14'h0, empty_flags});
      i_host.access(1'b1, gauge_pkg::ADDR_FULL_REF, 8'h66, rdata);
      rd16(gauge_pkg::ADDR_CAP_LO);
      check("capacity", exp_cap(102, f55[i], 0), word);
    end
    tally_and_finish();
  end
endmodule : test_gauge_core
